// file: hw/tcf_timer_ctrl.sv
// Control, status and flag logic of the 8/16-bit timer with its register port
//
// Overview of operation
// (RQ1) Control bit 9 enables the high-byte overflow interrupt.
// (RQ2) Control bit 8 enables the low-byte overflow interrupt.
// (RQ3) Bit 7 low-byte overflow flag, set by hardware, held until software clears.
// (RQ4) Bit 6 runs the low-byte counter when 1, halts it when 0.
// (RQ5) Bit 5 high-byte overflow flag, set by hardware, held until software clears.
// (RQ6) Bit 4 runs the high-byte counter when 1, halts it when 0.
// (RQ7) Bit 3 reads 1 once counting finished in event or clock-measurement sub-mode.
// (RQ8) Bit 2 picks read request source: 0 software, 1 hardware.
// (RQ9) Hardware read requests are ignored outside clock-measurement sub-mode.
// (RQ10) Software changes read source and read request in separate writes.
// (RQ11) Writing 1 to bit 1 requests a transfer; bit holds until done.
// (RQ12) Bit 0 low holds the timer in reset with its clock gated.
// (RQ13) Control register resets to 0x1: powered up, all else zero.
// (RQ14) Writing 1 to clear bit 7 clears the low-byte flag; self-clearing.
// (RQ15) Writing 1 to clear bit 5 clears the high-byte flag; self-clearing.
// (RQ16) Reserved bits of both registers read as zero.
// (RQ17) Two-bit mode field: 13-bit, 16-bit, 8-bit reload, split 8-bit.
// (RQ18) Two-bit sub-mode field: event 16-bit, dual 8-bit clock measurement.
// (RQ19) Each register write stalls the bus for the required cycle count.
// (RQ20) Overflow interrupt asserted while flag and enable are both set.
`timescale 1ns/1ps
`default_nettype none

module tcf_timer_ctrl
	import tcf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire tcf_bus_req_s bus_i,
	output logic bus_ready_o,
	output logic [31:0] bus_rdata_o,
	input wire tcf_evt_s evt_i,
	output logic low_counter_run_o,
	output logic high_counter_run_o,
	output logic xfer_req_o,
	output logic timer_rst_n_o,
	output logic clk_gate_en_o,
	output logic [1:0] timer_mode_o,
	output logic [1:0] timer_submode_o,
	output logic low_irq_o,
	output logic high_irq_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tcf_state_s st_ff;
	tcf_state_s nxt_st;
	logic taken;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_clr;
	logic clk_meas;
	logic hw_req_ok;
	logic done_mode;
	logic [31:0] ctrl_view;

	assign taken = bus_i.req && st_ff.ready;
	assign wr_ctrl = taken && bus_i.we && (bus_i.addr == TCF_CTRL_OFS);
	assign wr_mode = taken && bus_i.we && (bus_i.addr == TCF_MODE_OFS);
	assign wr_clr = taken && bus_i.we && (bus_i.addr == TCF_CLR_OFS);
	assign clk_meas = (st_ff.timer_mode_select == TCF_MODE_SPLIT) &&
		(st_ff.timer_submode_select == TCF_SUBM_CLKMEAS);
	assign done_mode = clk_meas || ((st_ff.timer_mode_select == TCF_MODE_16BIT) &&
		(st_ff.timer_submode_select == TCF_SUBM_EVENT));
	assign hw_req_ok = evt_i.hw_read_req && st_ff.read_source_select && clk_meas; // RQ9

	// Reserved positions stay zero by construction
	always_comb begin
		ctrl_view = 32'h0000_0000; // RQ16
		ctrl_view[TCF_HI_IE_BIT] = st_ff.high_overflow_irq_en;
		ctrl_view[TCF_LO_IE_BIT] = st_ff.low_overflow_irq_en;
		ctrl_view[TCF_LO_FLAG_BIT] = st_ff.low_overflow_flag;
		ctrl_view[TCF_LO_RUN_BIT] = st_ff.low_counter_run;
		ctrl_view[TCF_HI_FLAG_BIT] = st_ff.high_overflow_flag;
		ctrl_view[TCF_HI_RUN_BIT] = st_ff.high_counter_run;
		ctrl_view[TCF_DONE_BIT] = st_ff.count_done;
		ctrl_view[TCF_RDSRC_BIT] = st_ff.read_source_select;
		ctrl_view[TCF_RDREQ_BIT] = st_ff.value_read_request;
		ctrl_view[TCF_PDN_BIT] = st_ff.powerdown_n;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// Register writes
		if (wr_ctrl) begin
			nxt_st.high_overflow_irq_en = bus_i.wdata[TCF_HI_IE_BIT]; // RQ1
			nxt_st.low_overflow_irq_en = bus_i.wdata[TCF_LO_IE_BIT]; // RQ2
			nxt_st.low_counter_run = bus_i.wdata[TCF_LO_RUN_BIT]; // RQ4
			nxt_st.high_counter_run = bus_i.wdata[TCF_HI_RUN_BIT]; // RQ6
			nxt_st.count_done = bus_i.wdata[TCF_DONE_BIT];
			nxt_st.read_source_select = bus_i.wdata[TCF_RDSRC_BIT]; // RQ8
			nxt_st.powerdown_n = bus_i.wdata[TCF_PDN_BIT]; // RQ12
			// Judged against the source already stored, so a combined write fires only while the stored source is software
			if (bus_i.wdata[TCF_RDREQ_BIT] && !st_ff.read_source_select) begin
				nxt_st.value_read_request = 1'b1; // RQ11 RQ10
			end
		end
		if (wr_mode) begin
			nxt_st.timer_mode_select = tcf_mode_e'(bus_i.wdata[TCF_MODE_LSB +: 2]); // RQ17
			nxt_st.timer_submode_select = tcf_subm_e'(bus_i.wdata[TCF_SUBM_LSB +: 2]); // RQ18
		end
		if (wr_clr && bus_i.wdata[TCF_LO_CLR_BIT]) begin
			nxt_st.low_overflow_flag = 1'b0; // RQ14
		end
		if (wr_clr && bus_i.wdata[TCF_HI_CLR_BIT]) begin
			nxt_st.high_overflow_flag = 1'b0; // RQ15
		end

		// Hardware events come after the clears so that a set wins
		if (evt_i.xfer_done) begin
			nxt_st.value_read_request = 1'b0; // RQ11
		end
		if (hw_req_ok) begin
			nxt_st.value_read_request = 1'b1; // RQ8
		end
		if (evt_i.count_start) begin
			nxt_st.count_done = 1'b0; // RQ7
		end
		if (evt_i.count_finish && done_mode) begin
			nxt_st.count_done = 1'b1; // RQ7
		end
		if (evt_i.low_overflow) begin
			nxt_st.low_overflow_flag = 1'b1; // RQ3
		end
		if (evt_i.high_overflow) begin
			nxt_st.high_overflow_flag = 1'b1; // RQ5
		end

		// Power-down holds the timer side in its reset state
		if (!nxt_st.powerdown_n) begin
			nxt_st.low_overflow_flag = 1'b0; // RQ12
			nxt_st.high_overflow_flag = 1'b0;
			nxt_st.count_done = 1'b0;
			nxt_st.value_read_request = 1'b0;
		end

		// Write stall
		if (taken && bus_i.we) begin
			nxt_st.stall_cnt = 2'(TCF_STALL_CYC - 1); // RQ19
			nxt_st.ready = 1'b0;
		end else if (st_ff.stall_cnt != 2'h0) begin
			nxt_st.stall_cnt = st_ff.stall_cnt - 2'h1;
			nxt_st.ready = 1'b0;
		end else begin
			nxt_st.ready = 1'b1;
		end

		// Read data, one cycle after the read is taken
		if (taken && !bus_i.we) begin
			if (bus_i.addr == TCF_CTRL_OFS) begin
				nxt_st.rdata = ctrl_view;
			end else if (bus_i.addr == TCF_MODE_OFS) begin
				nxt_st.rdata = 32'h0000_0000;
				nxt_st.rdata[TCF_MODE_LSB +: 2] = st_ff.timer_mode_select;
				nxt_st.rdata[TCF_SUBM_LSB +: 2] = st_ff.timer_submode_select;
			end else begin
				nxt_st.rdata = 32'h0000_0000; // RQ16
			end
		end

		nxt_st.low_irq = nxt_st.low_overflow_flag && nxt_st.low_overflow_irq_en; // RQ20
		nxt_st.high_irq = nxt_st.high_overflow_flag && nxt_st.high_overflow_irq_en; // RQ20
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= '{
				high_overflow_irq_en: 1'b0,
				low_overflow_irq_en: 1'b0,
				low_overflow_flag: 1'b0,
				low_counter_run: 1'b0,
				high_overflow_flag: 1'b0,
				high_counter_run: 1'b0,
				count_done: 1'b0,
				read_source_select: 1'b0,
				value_read_request: 1'b0,
				powerdown_n: TCF_CTRL_RESET[TCF_PDN_BIT], // RQ13
				timer_mode_select: tcf_mode_e'(TCF_MODE_RESET[1:0]),
				timer_submode_select: TCF_SUBM_NONE,
				stall_cnt: 2'h0,
				ready: 1'b1,
				rdata: 32'h0000_0000,
				low_irq: 1'b0,
				high_irq: 1'b0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_ready_o = st_ff.ready;
	assign bus_rdata_o = st_ff.rdata;
	assign low_counter_run_o = st_ff.low_counter_run; // RQ4
	assign high_counter_run_o = st_ff.high_counter_run; // RQ6
	assign xfer_req_o = st_ff.value_read_request; // RQ11
	assign timer_rst_n_o = st_ff.powerdown_n; // RQ12
	assign clk_gate_en_o = st_ff.powerdown_n; // RQ12
	assign timer_mode_o = st_ff.timer_mode_select;
	assign timer_submode_o = st_ff.timer_submode_select;
	assign low_irq_o = st_ff.low_irq;
	assign high_irq_o = st_ff.high_irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence write_taken_s;
		bus_i.req && bus_ready_o && bus_i.we;
	endsequence

	sequence stall_window_s;
		!bus_ready_o [*3] ##1 bus_ready_o;
	endsequence

	write_stall_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ19
		write_taken_s |=> stall_window_s)
		else $error("write stall length wrong");

	low_flag_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ3
		evt_i.low_overflow && nxt_st.powerdown_n |=> ctrl_view[TCF_LO_FLAG_BIT])
		else $error("low overflow flag not set");

	high_flag_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ5
		evt_i.high_overflow && nxt_st.powerdown_n |=> ctrl_view[TCF_HI_FLAG_BIT])
		else $error("high overflow flag not set");

	low_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ14
		write_taken_s ##0 (bus_i.addr == TCF_CLR_OFS) && bus_i.wdata[TCF_LO_CLR_BIT] &&
		!evt_i.low_overflow |=> !ctrl_view[TCF_LO_FLAG_BIT])
		else $error("low overflow flag not cleared");

	high_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ15
		write_taken_s ##0 (bus_i.addr == TCF_CLR_OFS) && bus_i.wdata[TCF_HI_CLR_BIT] &&
		!evt_i.high_overflow |=> !ctrl_view[TCF_HI_FLAG_BIT])
		else $error("high overflow flag not cleared");

	sequence sw_req_s;
		wr_ctrl && bus_i.wdata[TCF_RDREQ_BIT] && !st_ff.read_source_select;
	endsequence

	sw_req_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ11
		sw_req_s ##0 bus_i.wdata[TCF_PDN_BIT] && !evt_i.xfer_done |=> xfer_req_o)
		else $error("software read request not raised");

	src_locked_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ11
		wr_ctrl && st_ff.read_source_select && !hw_req_ok && !xfer_req_o |=> !xfer_req_o)
		else $error("software read request taken with hardware source");

	done_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ7
		evt_i.count_finish && done_mode && nxt_st.powerdown_n |=> ctrl_view[TCF_DONE_BIT])
		else $error("count ready not set");

	done_blocked_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ7
		evt_i.count_finish && !done_mode && !ctrl_view[TCF_DONE_BIT] && !wr_ctrl |=>
		!ctrl_view[TCF_DONE_BIT])
		else $error("count ready set outside its sub-modes");

	run_follow_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ4 RQ6
		wr_ctrl |=> (low_counter_run_o == $past(bus_i.wdata[TCF_LO_RUN_BIT])) &&
		(high_counter_run_o == $past(bus_i.wdata[TCF_HI_RUN_BIT])))
		else $error("run control does not follow the write");

	irq_enable_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ1 RQ2
		(evt_i.low_overflow && nxt_st.low_overflow_irq_en && nxt_st.powerdown_n |=>
		low_irq_o) and (evt_i.high_overflow && nxt_st.high_overflow_irq_en &&
		nxt_st.powerdown_n |=> high_irq_o))
		else $error("enabled overflow raises no interrupt");

	read_no_stall_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ19
		bus_i.req && bus_ready_o && !bus_i.we |=> bus_ready_o)
		else $error("read stalled the bus");

	irq_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ20
		(low_irq_o == (ctrl_view[TCF_LO_FLAG_BIT] && ctrl_view[TCF_LO_IE_BIT])) &&
		(high_irq_o == (ctrl_view[TCF_HI_FLAG_BIT] && ctrl_view[TCF_HI_IE_BIT])))
		else $error("interrupt does not follow flag and enable");

	hw_req_ignore_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ9
		evt_i.hw_read_req && !clk_meas && !xfer_req_o && !wr_ctrl |=> !xfer_req_o)
		else $error("hardware read request taken outside clock measurement");

	req_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ11
		xfer_req_o && !evt_i.xfer_done && nxt_st.powerdown_n |=> xfer_req_o)
		else $error("read request dropped before transfer done");

	powerdown_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ12
		!ctrl_view[TCF_PDN_BIT] |-> !timer_rst_n_o && !clk_gate_en_o && !xfer_req_o &&
		!low_irq_o && !high_irq_o)
		else $error("power-down does not hold the timer");

	reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ16
		bus_i.req && bus_ready_o && !bus_i.we && (bus_i.addr != TCF_MODE_OFS) |=>
		bus_rdata_o[31:TCF_CTRL_WIDTH] == 22'h0)
		else $error("reserved bits read nonzero");

endmodule

`default_nettype wire

// file: hw/tcf_pkg.sv
// Package: register map, field positions, reset values and timing of the timer control block
package tcf_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TCF_CTRL_OFS = 8'h0C;
	localparam logic [7:0] TCF_MODE_OFS = 8'h10;
	localparam logic [7:0] TCF_CLR_OFS = 8'h14;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int TCF_HI_IE_BIT = 9;
	localparam int TCF_LO_IE_BIT = 8;
	localparam int TCF_LO_FLAG_BIT = 7;
	localparam int TCF_LO_RUN_BIT = 6;
	localparam int TCF_HI_FLAG_BIT = 5;
	localparam int TCF_HI_RUN_BIT = 4;
	localparam int TCF_DONE_BIT = 3;
	localparam int TCF_RDSRC_BIT = 2;
	localparam int TCF_RDREQ_BIT = 1;
	localparam int TCF_PDN_BIT = 0;
	localparam int TCF_CTRL_WIDTH = 10;
	localparam logic [31:0] TCF_CTRL_RESET = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Clear register fields
	// ----------------------------------------------------------------
	localparam int TCF_LO_CLR_BIT = 7;
	localparam int TCF_HI_CLR_BIT = 5;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int TCF_MODE_LSB = 0;
	localparam int TCF_SUBM_LSB = 6;
	localparam logic [31:0] TCF_MODE_RESET = 32'h0000_0001;

	typedef enum logic [1:0] {
		TCF_MODE_13BIT = 2'h0,
		TCF_MODE_16BIT = 2'h1,
		TCF_MODE_RELOAD = 2'h2,
		TCF_MODE_SPLIT = 2'h3
	} tcf_mode_e;

	typedef enum logic [1:0] {
		TCF_SUBM_NONE = 2'h0,
		TCF_SUBM_EVENT = 2'h1,
		TCF_SUBM_CLKMEAS = 2'h2,
		TCF_SUBM_RSVD = 2'h3
	} tcf_subm_e;

	// ----------------------------------------------------------------
	// Bus stall after a write, in cycles of each clock
	// ----------------------------------------------------------------
	localparam int TCF_STALL_TMR_CYC = 2;
	localparam int TCF_STALL_BUS_CYC = 3;
	// Both clocks are the same here, so the longer figure governs
	localparam int TCF_STALL_CYC = (TCF_STALL_TMR_CYC > TCF_STALL_BUS_CYC) ?
		TCF_STALL_TMR_CYC : TCF_STALL_BUS_CYC;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic req;
		logic we;
		logic [7:0] addr;
		logic [31:0] wdata;
	} tcf_bus_req_s;

	typedef struct packed {
		logic low_overflow;
		logic high_overflow;
		logic count_start;
		logic count_finish;
		logic hw_read_req;
		logic xfer_done;
	} tcf_evt_s;

	typedef struct packed {
		logic high_overflow_irq_en;
		logic low_overflow_irq_en;
		logic low_overflow_flag;
		logic low_counter_run;
		logic high_overflow_flag;
		logic high_counter_run;
		logic count_done;
		logic read_source_select;
		logic value_read_request;
		logic powerdown_n;
		tcf_mode_e timer_mode_select;
		tcf_subm_e timer_submode_select;
		logic [1:0] stall_cnt;
		logic ready;
		logic [31:0] rdata;
		logic low_irq;
		logic high_irq;
	} tcf_state_s;

endpackage

// file: tb/tcf_timer_ctrl_test.sv
// Self-checking testbench of the timer control, status and flag block
`timescale 1ns/1ps
`default_nettype none

module tcf_timer_ctrl_test
	import tcf_pkg::*;
;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	tcf_bus_req_s bus = '0;
	tcf_evt_s evt = '0;
	logic bus_ready_o, low_counter_run_o, high_counter_run_o, xfer_req_o;
	logic timer_rst_n_o, clk_gate_en_o, low_irq_o, high_irq_o;
	logic [31:0] bus_rdata_o;
	logic [1:0] timer_mode_o, timer_submode_o;
	logic [31:0] rd;
	int miscompares = 0;
	int n_compared = 0;
	int stall_n;

	tcf_timer_ctrl dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .bus_i(bus),
		.bus_ready_o(bus_ready_o), .bus_rdata_o(bus_rdata_o), .evt_i(evt),
		.low_counter_run_o(low_counter_run_o), .high_counter_run_o(high_counter_run_o),
		.xfer_req_o(xfer_req_o), .timer_rst_n_o(timer_rst_n_o),
		.clk_gate_en_o(clk_gate_en_o), .timer_mode_o(timer_mode_o),
		.timer_submode_o(timer_submode_o), .low_irq_o(low_irq_o), .high_irq_o(high_irq_o));

	always #5 mclk_i = ~mclk_i;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %08h expected %08h", $time, got, exp);
		end
	endtask

	// Ready is a register, so it is settled at the falling edge before a take
	// Request stands over exactly one taking edge; a second edge would repeat a read, as ready stays high after it
	task automatic access(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		bus <= '{req: 1'b1, we: we, addr: a, wdata: d};
		while (bus_ready_o !== 1'b1) @(negedge mclk_i);
		@(negedge mclk_i);
		bus.req <= 1'b0;
		rd = bus_rdata_o;
		stall_n = 0;
		while (bus_ready_o !== 1'b1 && stall_n < 9) begin
			stall_n++;
			@(negedge mclk_i);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		access(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		access(1'b0, a, '0);
		chk(rd, exp);
	endtask

	// One-cycle event pulse from the counter side
	task automatic pulse(input logic [5:0] e);
		@(negedge mclk_i);
		evt <= tcf_evt_s'(e);
		@(negedge mclk_i);
		evt <= '0;
		@(negedge mclk_i);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_chk(TCF_CTRL_OFS, TCF_CTRL_RESET);
		rd_chk(TCF_MODE_OFS, TCF_MODE_RESET);
		rd_chk(TCF_CLR_OFS, 32'h0000_0000);
		chk({timer_rst_n_o, clk_gate_en_o, low_counter_run_o, high_counter_run_o}, 32'h0C);
		wr(8'h00, 32'hFFFF_FFFF);
		rd_chk(8'h00, 32'h0000_0000);
	endtask

	task automatic t_ctrl_write();
		wr(TCF_CTRL_OFS, 32'hFFFF_FFFF);
		chk(stall_n, 3);
		rd_chk(TCF_CTRL_OFS, 32'h0000_035F);
		chk({low_counter_run_o, high_counter_run_o, xfer_req_o}, 32'h7);
		pulse(6'h01);
		rd_chk(TCF_CTRL_OFS, 32'h0000_035D);
		wr(TCF_CTRL_OFS, 32'h0000_0001);
		chk({low_counter_run_o, high_counter_run_o}, 32'h0);
	endtask

	task automatic t_ovf(input bit hi);
		logic [31:0] fb, ie;
		fb = hi ? 32'h20 : 32'h80;
		ie = hi ? 32'h200 : 32'h100;
		pulse(hi ? 6'h10 : 6'h20);
		rd_chk(TCF_CTRL_OFS, 32'h1 | fb);
		chk(hi ? high_irq_o : low_irq_o, 32'h0);
		wr(TCF_CTRL_OFS, 32'h1 | ie);
		chk({low_irq_o, high_irq_o}, hi ? 32'h1 : 32'h2);
		wr(TCF_CLR_OFS, hi ? 32'h80 : 32'h20);
		rd_chk(TCF_CTRL_OFS, 32'h1 | ie | fb);
		wr(TCF_CLR_OFS, fb);
		rd_chk(TCF_CTRL_OFS, 32'h1 | ie);
		chk({low_irq_o, high_irq_o}, 32'h0);
		rd_chk(TCF_CLR_OFS, 32'h0);
		wr(TCF_CTRL_OFS, 32'h1);
	endtask

	task automatic t_read_source();
		wr(TCF_MODE_OFS, 32'h01);
		wr(TCF_CTRL_OFS, 32'h05);
		pulse(6'h02);
		chk(xfer_req_o, 32'h0);
		wr(TCF_CTRL_OFS, 32'h07);
		rd_chk(TCF_CTRL_OFS, 32'h05);
		wr(TCF_MODE_OFS, 32'h83);
		pulse(6'h02);
		chk(xfer_req_o, 32'h1);
		rd_chk(TCF_CTRL_OFS, 32'h07);
		pulse(6'h01);
		chk(xfer_req_o, 32'h0);
		wr(TCF_CTRL_OFS, 32'h01);
		pulse(6'h02);
		chk(xfer_req_o, 32'h0);
		wr(TCF_CTRL_OFS, 32'h03);
		chk(xfer_req_o, 32'h1);
		pulse(6'h01);
		rd_chk(TCF_CTRL_OFS, 32'h01);
	endtask

	task automatic t_modes();
		logic [1:0] m, s;
		logic done;
		for (int i = 0; i < 16; i++) begin
			m = i[1:0];
			s = i[3:2];
			done = (m == 2'h1 && s == 2'h1) || (m == 2'h3 && s == 2'h2);
			wr(TCF_MODE_OFS, {24'h0, s, 4'h0, m});
			rd_chk(TCF_MODE_OFS, {24'h0, s, 4'h0, m});
			chk({timer_submode_o, timer_mode_o}, {28'h0, s, m});
			pulse(6'h04);
			rd_chk(TCF_CTRL_OFS, {28'h0, done, 3'h1});
			pulse(6'h08);
			rd_chk(TCF_CTRL_OFS, 32'h1);
		end
	endtask

	task automatic t_powerdown();
		wr(TCF_CTRL_OFS, 32'h301);
		pulse(6'h30);
		chk({low_irq_o, high_irq_o}, 32'h3);
		wr(TCF_CTRL_OFS, 32'h300);
		chk({timer_rst_n_o, clk_gate_en_o, low_irq_o, high_irq_o}, 32'h0);
		rd_chk(TCF_CTRL_OFS, 32'h300);
		pulse(6'h30);
		rd_chk(TCF_CTRL_OFS, 32'h300);
		wr(TCF_CTRL_OFS, 32'h1);
		chk({timer_rst_n_o, clk_gate_en_o}, 32'h3);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk_i);
		@(negedge mclk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_ctrl_write();
		t_ovf(1'b0);
		t_ovf(1'b1);
		t_read_source();
		t_modes();
		t_powerdown();
		finish_test();
	end

	// Whole run needs about 450 cycles; over forty times that is a hang
	initial begin
		#200us;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
